// >>> common/mfio_pkg.sv
`default_nettype none
// ------------------------------------------------------------
// register map and field constants
// ------------------------------------------------------------
package mfio_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;

	localparam logic [11:0] OFS_SER_LATCH = 12'h004;
	localparam logic [11:0] OFS_I2C_LATCH = 12'h005;
	localparam logic [11:0] OFS_AN_LATCH = 12'h006;
	localparam logic [11:0] OFS_SER_DRIVE = 12'h00A;
	localparam logic [11:0] OFS_SER_PINS = 12'h00E;
	localparam logic [11:0] OFS_I2C_PINS = 12'h00F;
	localparam logic [11:0] OFS_AN_DIR = 12'hF9B;
	localparam logic [11:0] OFS_AN_IEN = 12'hF9C;
	localparam logic [11:0] OFS_KEY_SEL = 12'hFA0;

	localparam logic [7:0] RST_SER_LATCH = 8'hFF;
	localparam logic [7:0] RST_SER_DRIVE = 8'h00;
	localparam logic [7:0] RST_I2C_LATCH = 8'hFF;
	localparam logic [7:0] RST_AN_LATCH = 8'h00;
	localparam logic [7:0] RST_AN_DIR = 8'h00;
	localparam logic [7:0] RST_AN_IEN = 8'hFF;
	localparam logic [7:0] RST_KEY_SEL = 8'h00;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	localparam int SER_W = 8;
	localparam int I2C_W = 5;
	localparam int AN_W = 8;
	// key-on wakeup lives on the upper nibble of the analog port
	localparam int KEY_LO = 4;
	localparam int KEY_N = 4;
endpackage
`default_nettype wire

// >>> logic/mfio_ports.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mfio_ports #(
	parameter int SER_W = mfio_pkg::SER_W,
	parameter int I2C_W = mfio_pkg::I2C_W,
	parameter int AN_W = mfio_pkg::AN_W
) (
	input wire logic CLK_SYS, // system clock, 50 MHz
	input wire logic RESET_N, // async reset, active low
	input wire logic [11:0] REG_ADDR, // register address
	input wire logic [7:0] REG_WDATA, // write data
	input wire logic REG_WR, // write strobe
	input wire logic REG_RD, // read strobe
	output logic [7:0] REG_RDATA, // read data, cycle after strobe
	input wire logic [SER_W-1:0] SER_FUNC_OUT, // serial/uart drive, 1 idle
	input wire logic [I2C_W-1:0] I2C_FUNC_OUT, // i2c drive, 1 idle
	input wire logic [SER_W-1:0] SER_PIN_IN, // serial port pin levels
	output logic [SER_W-1:0] SER_PIN_OUT, // serial port pin drive level
	output logic [SER_W-1:0] SER_PIN_OE_N, // serial port enable, low drives
	input wire logic [I2C_W-1:0] I2C_PIN_IN, // i2c port pin levels
	output logic [I2C_W-1:0] I2C_PIN_OUT, // i2c port pin drive level
	output logic [I2C_W-1:0] I2C_PIN_OE_N, // i2c port enable, low drives
	input wire logic [AN_W-1:0] AN_PIN_IN, // analog port pin levels
	output logic [AN_W-1:0] AN_PIN_OUT, // analog port pin drive level
	output logic [AN_W-1:0] AN_PIN_OE_N, // analog port enable, low drives
	output logic [SER_W-1:0] SER_PIN_LEVEL, // synced pins to peripherals
	output logic [I2C_W-1:0] I2C_PIN_LEVEL, // synced pins to i2c engine
	output logic [AN_W-1:0] AN_DIG_IN_EN, // digital input path enabled
	output logic [3:0] KEY_WAKE // gated key-on wakeup levels
);
	// ------------------------------------------------------------
	// parameter checks
	// ------------------------------------------------------------
	if (SER_W < 1 || SER_W > mfio_pkg::DATA_W) begin : g_bad_ser
		$error("serial port width out of range");
	end
	if (I2C_W < 1 || I2C_W > mfio_pkg::DATA_W) begin : g_bad_i2c
		$error("i2c port width out of range");
	end
	if (AN_W != mfio_pkg::KEY_LO + mfio_pkg::KEY_N) begin : g_bad_an
		$error("analog port width must cover the wakeup nibble");
	end

	// ------------------------------------------------------------
	// reset release and pin synchronisers
	// ------------------------------------------------------------
	logic rst_n;
	logic [SER_W-1:0] ser_pin_s;
	logic [I2C_W-1:0] i2c_pin_s;
	logic [AN_W-1:0] an_pin_s;

	mfio_sync #(.W(1)) u_rst_sync (
		.clk(CLK_SYS),
		.rst_n(RESET_N),
		.d(1'b1),
		.q(rst_n)
	);
	mfio_sync #(.W(SER_W)) u_ser_sync (
		.clk(CLK_SYS),
		.rst_n(rst_n),
		.d(SER_PIN_IN),
		.q(ser_pin_s)
	);
	mfio_sync #(.W(I2C_W)) u_i2c_sync (
		.clk(CLK_SYS),
		.rst_n(rst_n),
		.d(I2C_PIN_IN),
		.q(i2c_pin_s)
	);
	mfio_sync #(.W(AN_W)) u_an_sync (
		.clk(CLK_SYS),
		.rst_n(rst_n),
		.d(AN_PIN_IN),
		.q(an_pin_s)
	);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [SER_W-1:0] ser_latch;
		logic [SER_W-1:0] ser_drive;
		logic [I2C_W-1:0] i2c_latch;
		logic [AN_W-1:0] an_latch;
		logic [AN_W-1:0] an_dir;
		logic [AN_W-1:0] an_ien;
		logic [3:0] key_sel;
		logic [7:0] rdata;
		logic [SER_W-1:0] ser_out;
		logic [SER_W-1:0] ser_oe_n;
		logic [I2C_W-1:0] i2c_out;
		logic [I2C_W-1:0] i2c_oe_n;
		logic [AN_W-1:0] an_out;
		logic [AN_W-1:0] an_oe_n;
		logic [AN_W-1:0] an_dig_en;
		logic [3:0] wake;
	} mfio_state_t;

	mfio_state_t state_ff;
	mfio_state_t nxt_state;

	function automatic logic hit(input logic [11:0] a,
			input logic [11:0] ofs);
		hit = (a == ofs);
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	logic [SER_W-1:0] ser_val;
	logic [I2C_W-1:0] i2c_val;
	logic [7:0] rd_mux;
	logic [7:0] an_view;

	always_comb begin
		nxt_state = state_ff;
		rd_mux = mfio_pkg::RD_UNMAPPED;
		an_view = '0;

		// whole-byte writes: a read-modify-write of an analog input bit stores
		// the pin level, or zero when its input is cut off, read back from the analog data view into the latch
		if (REG_WR) begin
			if (hit(REG_ADDR, mfio_pkg::OFS_SER_LATCH)) begin
				nxt_state.ser_latch = REG_WDATA[SER_W-1:0];
			end
			if (hit(REG_ADDR, mfio_pkg::OFS_SER_DRIVE)) begin
				nxt_state.ser_drive = REG_WDATA[SER_W-1:0];
			end
			if (hit(REG_ADDR, mfio_pkg::OFS_I2C_LATCH)) begin
				nxt_state.i2c_latch = REG_WDATA[I2C_W-1:0];
			end
			if (hit(REG_ADDR, mfio_pkg::OFS_AN_LATCH)) begin
				nxt_state.an_latch = REG_WDATA[AN_W-1:0];
			end
			if (hit(REG_ADDR, mfio_pkg::OFS_AN_DIR)) begin
				nxt_state.an_dir = REG_WDATA[AN_W-1:0];
			end
			if (hit(REG_ADDR, mfio_pkg::OFS_AN_IEN)) begin
				nxt_state.an_ien = REG_WDATA[AN_W-1:0];
			end
			if (hit(REG_ADDR, mfio_pkg::OFS_KEY_SEL)) begin
				nxt_state.key_sel = REG_WDATA[3:0];
			end
		end

		// analog data view: latch, pin, or zero when input is cut off
		for (int i = 0; i < AN_W; i++) begin
			if (state_ff.an_dir[i]) begin
				an_view[i] = state_ff.an_latch[i];
			end else if (state_ff.an_ien[i]) begin
				an_view[i] = an_pin_s[i];
			end else begin
				an_view[i] = 1'b0;
			end
		end

		// undefined upper i2c bits read as zero
		if (REG_RD) begin
			unique case (REG_ADDR)
				mfio_pkg::OFS_SER_LATCH: rd_mux[SER_W-1:0] = state_ff.ser_latch;
				mfio_pkg::OFS_SER_PINS: rd_mux[SER_W-1:0] = ser_pin_s;
				mfio_pkg::OFS_SER_DRIVE: rd_mux[SER_W-1:0] = state_ff.ser_drive;
				mfio_pkg::OFS_I2C_LATCH: rd_mux[I2C_W-1:0] = state_ff.i2c_latch;
				mfio_pkg::OFS_I2C_PINS: rd_mux[I2C_W-1:0] = i2c_pin_s;
				mfio_pkg::OFS_AN_LATCH: rd_mux = an_view;
				mfio_pkg::OFS_AN_DIR: rd_mux[AN_W-1:0] = state_ff.an_dir;
				mfio_pkg::OFS_AN_IEN: rd_mux[AN_W-1:0] = state_ff.an_ien;
				mfio_pkg::OFS_KEY_SEL: rd_mux[3:0] = state_ff.key_sel;
				default: rd_mux = mfio_pkg::RD_UNMAPPED;
			endcase
		end
		nxt_state.rdata = rd_mux;

		// pin drivers follow the new register values in the same edge
		ser_val = nxt_state.ser_latch & SER_FUNC_OUT;
		for (int i = 0; i < SER_W; i++) begin
			if (nxt_state.ser_drive[i]) begin
				nxt_state.ser_out[i] = ser_val[i];
				nxt_state.ser_oe_n[i] = 1'b0;
			end else begin
				nxt_state.ser_out[i] = 1'b0;
				nxt_state.ser_oe_n[i] = ser_val[i];
			end
		end

		// the i2c pins sink only, so the bus can be wire-anded
		i2c_val = nxt_state.i2c_latch & I2C_FUNC_OUT;
		nxt_state.i2c_out = '0;
		nxt_state.i2c_oe_n = i2c_val;

		nxt_state.an_out = nxt_state.an_latch;
		nxt_state.an_oe_n = ~nxt_state.an_dir;
		nxt_state.an_dig_en = ~nxt_state.an_dir & nxt_state.an_ien;

		// wakeup takes the synced level; no filter on the pin itself
		nxt_state.wake = an_pin_s[AN_W-1:mfio_pkg::KEY_LO] &
			nxt_state.key_sel &
			~nxt_state.an_dir[AN_W-1:mfio_pkg::KEY_LO];
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			state_ff.ser_latch <= SER_W'(mfio_pkg::RST_SER_LATCH);
			state_ff.ser_drive <= SER_W'(mfio_pkg::RST_SER_DRIVE);
			state_ff.i2c_latch <= I2C_W'(mfio_pkg::RST_I2C_LATCH);
			state_ff.an_latch <= AN_W'(mfio_pkg::RST_AN_LATCH);
			state_ff.an_dir <= AN_W'(mfio_pkg::RST_AN_DIR);
			state_ff.an_ien <= AN_W'(mfio_pkg::RST_AN_IEN);
			state_ff.key_sel <= 4'(mfio_pkg::RST_KEY_SEL);
			state_ff.rdata <= mfio_pkg::RD_UNMAPPED;
			state_ff.ser_out <= '0;
			state_ff.ser_oe_n <= '1;
			state_ff.i2c_out <= '0;
			state_ff.i2c_oe_n <= '1;
			state_ff.an_out <= '0;
			state_ff.an_oe_n <= '1;
			state_ff.an_dig_en <= '1;
			state_ff.wake <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign REG_RDATA = state_ff.rdata;
	assign SER_PIN_OUT = state_ff.ser_out;
	assign SER_PIN_OE_N = state_ff.ser_oe_n;
	assign I2C_PIN_OUT = state_ff.i2c_out;
	assign I2C_PIN_OE_N = state_ff.i2c_oe_n;
	assign AN_PIN_OUT = state_ff.an_out;
	assign AN_PIN_OE_N = state_ff.an_oe_n;
	assign SER_PIN_LEVEL = ser_pin_s;
	assign I2C_PIN_LEVEL = i2c_pin_s;
	assign AN_DIG_IN_EN = state_ff.an_dig_en;
	assign KEY_WAKE = state_ff.wake;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_reset_serial: assert property (
		@(posedge CLK_SYS) $rose(rst_n) |->
			state_ff.ser_latch == SER_W'(mfio_pkg::RST_SER_LATCH) &&
			state_ff.ser_drive == SER_W'(mfio_pkg::RST_SER_DRIVE) &&
			SER_PIN_OE_N == '1)
		else $error("serial port reset values wrong");

	a_reset_i2c_analog: assert property (
		@(posedge CLK_SYS) $rose(rst_n) |->
			state_ff.i2c_latch == I2C_W'(mfio_pkg::RST_I2C_LATCH) &&
			state_ff.an_ien == AN_W'(mfio_pkg::RST_AN_IEN) &&
			AN_PIN_OE_N == '1)
		else $error("i2c or analog reset values wrong");

	a_od_never_high: assert property (
		@(posedge CLK_SYS) disable iff (!rst_n)
		(~SER_PIN_OE_N & SER_PIN_OUT & ~state_ff.ser_drive) == '0)
		else $error("open-drain serial pin driven high");

	a_latch_write_next: assert property (
		@(posedge CLK_SYS) disable iff (!rst_n)
		REG_WR && REG_ADDR == mfio_pkg::OFS_SER_LATCH &&
			REG_WDATA[SER_W-1:0] == '0 && SER_FUNC_OUT == '1 |=>
			state_ff.ser_latch == '0 && SER_PIN_OE_N == '0 &&
			SER_PIN_OUT == '0)
		else $error("serial latch write did not reach pins next edge");

	a_ser_latch_read: assert property (
		@(posedge CLK_SYS) disable iff (!rst_n)
		REG_RD && REG_ADDR == mfio_pkg::OFS_SER_LATCH |=>
			REG_RDATA[SER_W-1:0] == $past(state_ff.ser_latch) ##1
			REG_RDATA == mfio_pkg::RD_UNMAPPED || $past(REG_RD))
		else $error("serial latch read wrong");

	a_ser_pin_read: assert property (
		@(posedge CLK_SYS) disable iff (!rst_n)
		REG_RD && REG_ADDR == mfio_pkg::OFS_SER_PINS |=>
			REG_RDATA[SER_W-1:0] == $past(ser_pin_s))
		else $error("serial pin-level read wrong");

	a_i2c_upper_zero: assert property (
		@(posedge CLK_SYS) disable iff (!rst_n)
		REG_RD && (REG_ADDR == mfio_pkg::OFS_I2C_LATCH ||
			REG_ADDR == mfio_pkg::OFS_I2C_PINS) |=>
			REG_RDATA[7:I2C_W] == '0)
		else $error("i2c upper read bits not zero");

	a_an_read_view: assert property (
		@(posedge CLK_SYS) disable iff (!rst_n)
		REG_RD && REG_ADDR == mfio_pkg::OFS_AN_LATCH |=>
			(REG_RDATA & $past(~state_ff.an_dir & ~state_ff.an_ien)) == '0
			&& (REG_RDATA & $past(state_ff.an_dir)) ==
			($past(state_ff.an_latch) & $past(state_ff.an_dir)))
		else $error("analog data read view wrong");

	a_an_dir_drive: assert property (
		@(posedge CLK_SYS) disable iff (!rst_n)
		REG_WR && REG_ADDR == mfio_pkg::OFS_AN_DIR |=>
			AN_PIN_OE_N == ~$past(REG_WDATA[AN_W-1:0]) &&
			AN_PIN_OUT == state_ff.an_latch)
		else $error("analog direction write not on pins");

	a_key_wake_gate: assert property (
		@(posedge CLK_SYS) disable iff (!rst_n)
		(KEY_WAKE & ~(state_ff.key_sel &
			~state_ff.an_dir[AN_W-1:mfio_pkg::KEY_LO])) == '0)
		else $error("key wakeup passed an unselected line");
endmodule
`default_nettype wire

// >>> logic/mfio_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// two-stage synchroniser, async reset to zero
// ------------------------------------------------------------
module mfio_sync #(
	parameter int W = 1
) (
	input wire logic clk, // sampling clock
	input wire logic rst_n, // async reset, active low
	input wire logic [W-1:0] d, // asynchronous input
	output logic [W-1:0] q // synchronised output
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= d;
			sync_ff <= meta_ff;
		end
	end

	assign q = sync_ff;
endmodule
`default_nettype wire

// >>> test/mfio_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------
// lines outside the ports: pull-ups and far drivers
// --------------------
module mfio_pins_model (
	input wire logic [7:0] ser_out, // serial drive level
	input wire logic [7:0] ser_oe_n, // serial enable, low drives
	input wire logic [7:0] ser_sink, // far devices sinking serial lines
	output logic [7:0] ser_lvl, // serial line levels
	input wire logic [4:0] i2c_out, // i2c drive level
	input wire logic [4:0] i2c_oe_n, // i2c enable, low sinks
	input wire logic [4:0] i2c_sink, // far devices sinking i2c lines
	output logic [4:0] i2c_lvl, // i2c line levels
	input wire logic [7:0] an_out, // analog port drive level
	input wire logic [7:0] an_oe_n, // analog port enable, low drives
	input wire logic [7:0] an_src, // outside source on released lines
	output logic [7:0] an_lvl // analog port line levels
);
	// released open-drain lines rest at the pull-up unless sunk outside
	assign ser_lvl = (ser_oe_n & ~ser_sink) | (~ser_oe_n & ser_out);
	assign i2c_lvl = (i2c_oe_n & ~i2c_sink) | (~i2c_oe_n & i2c_out);
	// no pull here, so the bench always supplies a fresh source value
	assign an_lvl = (an_oe_n & an_src) | (~an_oe_n & an_out);
endmodule
`default_nettype wire

// >>> test/mfio_ports_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mfio_ports_tb;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [7:0] wdata = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [7:0] rdata, s_in, s_out, s_oe_n, a_in, a_out, a_oe_n, a_den;
	logic [4:0] i_in, i_out, i_oe_n;
	logic [3:0] kw;
	logic [7:0] s_lv;
	logic [4:0] i_lv;
	logic [7:0] sf = 8'hFF, sp = 8'h00, ae = 8'h00;
	logic [4:0] ifn = 5'h1F, ip = 5'h00;
	logic [7:0] d, sl, sd, il, al, ad, ai, ks, e;
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;

	always #10 clk = ~clk;

	mfio_ports dut (.CLK_SYS(clk), .RESET_N(reset_n), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata),
		.SER_FUNC_OUT(sf), .I2C_FUNC_OUT(ifn), .SER_PIN_IN(s_in),
		.SER_PIN_OUT(s_out), .SER_PIN_OE_N(s_oe_n), .I2C_PIN_IN(i_in),
		.I2C_PIN_OUT(i_out), .I2C_PIN_OE_N(i_oe_n), .AN_PIN_IN(a_in),
		.AN_PIN_OUT(a_out), .AN_PIN_OE_N(a_oe_n), .SER_PIN_LEVEL(s_lv),
		.I2C_PIN_LEVEL(i_lv), .AN_DIG_IN_EN(a_den), .KEY_WAKE(kw));
	mfio_pins_model pins (.ser_out(s_out), .ser_oe_n(s_oe_n), .ser_sink(sp),
		.ser_lvl(s_in), .i2c_out(i_out), .i2c_oe_n(i_oe_n), .i2c_sink(ip),
		.i2c_lvl(i_in), .an_out(a_out), .an_oe_n(a_oe_n), .an_src(ae),
		.an_lvl(a_in));

	// --------------------
	// bus cycles and comparison
	// --------------------
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		@(posedge clk);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [7:0] v);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		// read data launched by the strobe edge still stands here
		@(posedge clk);
		v = rdata;
	endtask
	task automatic check(input string what, input logic [7:0] x, y);
		compares++;
		if (y !== x) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, x, y);
		end
	endtask
	task automatic end_of_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// level seen on an open-drain or push-pull line with pull-up
	function automatic logic [7:0] od_lvl(input logic [7:0] oe_n, o, snk);
		return (oe_n & ~snk) | (~oe_n & o);
	endfunction

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			end_of_test();
		end
	end

	initial begin
		logic [11:0] ra[7];
		logic [7:0] re[7];
		ra = '{mfio_pkg::OFS_SER_LATCH, mfio_pkg::OFS_SER_DRIVE,
			mfio_pkg::OFS_I2C_LATCH, mfio_pkg::OFS_AN_LATCH,
			mfio_pkg::OFS_AN_DIR, mfio_pkg::OFS_AN_IEN, 12'h123};
		re = '{8'hFF, 8'h00, 8'h1F, 8'h00, 8'h00, 8'hFF, 8'h00};
		void'($urandom(17));
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		check("ser oe_n", 8'hFF, s_oe_n);
		check("an oe_n", 8'hFF, a_oe_n);
		check("an dig en", 8'hFF, a_den);
		foreach (ra[i]) begin
			rd(ra[i], d);
			check("reset value", re[i], d);
		end
		$display("test reset values done");
		for (int n = 0; n < 40; n++) begin
			sl = 8'($urandom);
			sd = 8'($urandom);
			il = 8'($urandom);
			al = 8'($urandom);
			ai = 8'($urandom);
			ad = 8'($urandom) & ai;
			ks = 8'($urandom);
			if (n < 2) begin
				// corners: all serial pins and i2c latch bits input-ready, then all driven low
				sl = n ? 8'h00 : 8'hFF;
				sd = 8'h00;
				il = n ? 8'h00 : 8'hFF;
			end
			sf <= n < 2 ? 8'hFF : 8'($urandom);
			sp <= 8'($urandom);
			ifn <= 5'($urandom);
			ip <= 5'($urandom);
			ae <= 8'($urandom);
			wr(mfio_pkg::OFS_SER_LATCH, sl);
			wr(mfio_pkg::OFS_SER_DRIVE, sd);
			wr(mfio_pkg::OFS_I2C_LATCH, il);
			wr(mfio_pkg::OFS_AN_LATCH, al);
			wr(mfio_pkg::OFS_AN_DIR, 8'h00);
			wr(mfio_pkg::OFS_AN_IEN, ai);
			wr(mfio_pkg::OFS_AN_DIR, ad);
			wr(mfio_pkg::OFS_KEY_SEL, ks);
			wr(mfio_pkg::OFS_SER_PINS, ~sl);
			wr(12'h7FF, 8'h5A);
			repeat (4) @(posedge clk);
			e = ~sd & sl & sf;
			check("ser oe_n", e, s_oe_n);
			check("ser out", sd & sl & sf, s_out);
			check("ser level", od_lvl(e, sd & sl & sf, sp), s_lv);
			check("i2c level", od_lvl({3'h0, il[4:0] & ifn}, 8'h00,
				{3'h0, ip}), {3'h0, i_lv});
			check("i2c oe_n", {3'h0, il[4:0] & ifn}, {3'h0, i_oe_n});
			check("an oe_n", ~ad, a_oe_n);
			check("an out", al, a_out);
			check("an dig en", ~ad & ai, a_den);
			check("key wake", {4'h0, ae[7:4] & ks[3:0] & ~ad[7:4]}, {4'h0, kw});
			rd(mfio_pkg::OFS_SER_LATCH, d);
			check("ser latch", sl, d);
			rd(mfio_pkg::OFS_SER_DRIVE, d);
			check("ser drive", sd, d);
			rd(mfio_pkg::OFS_SER_PINS, d);
			check("ser pins", od_lvl(e, sd & sl & sf, sp), d);
			rd(mfio_pkg::OFS_I2C_LATCH, d);
			check("i2c latch", {3'h0, il[4:0]}, d);
			rd(mfio_pkg::OFS_I2C_PINS, d);
			e = {3'h0, il[4:0] & ifn};
			check("i2c pins", od_lvl(e, 8'h00, {3'h0, ip}) & 8'h1F, d);
			rd(mfio_pkg::OFS_AN_LATCH, d);
			check("an data", (ad & al) | (~ad & ai & ae), d);
			rd(mfio_pkg::OFS_AN_DIR, d);
			check("an dir", ad, d);
			rd(mfio_pkg::OFS_AN_IEN, d);
			check("an ien", ai, d);
			rd(mfio_pkg::OFS_KEY_SEL, d);
			check("key sel", {4'h0, ks[3:0]}, d);
			$display("test random pass %0d done", n);
		end
		end_of_test();
	end
endmodule
`default_nettype wire
